// [logic/signal_selector.sv]
// Purpose: selects one control value from two to four redundant channels
// Assumes: inputs synchronous to clk_sys; quality and bypass flags per channel
// Notes: one cycle from inputs to registered outputs
//
// Operation
// - classify each input good or bad before selecting
// - four good inputs: output their median
// - any configured input bad: raise operator notification
// - two-input config, both good: pass the operator-chosen input
// - two-input config, both bad: hand loop to manual control
// - two-input config, one good: pass that input
// - three inputs all good: output the middle-ranked value
// - three inputs, one bad: output average of remaining two
// - three inputs, two bad: output the lone good input
// - three inputs all bad: manual control and operator alert
// - four inputs: bypassed or bad channel excluded, rest as three
// - four inputs, two bad: output average of the two good
// - four inputs, one good: output that value
// - four inputs all bad: manual control and operator alert
`default_nettype none
module signal_selector
  import selector_pkg::*;
#(
  parameter int VAL_W = VAL_W_DEF,
  parameter logic [VAL_W-1:0] RANGE_LO = RANGE_LO_DEF,
  parameter logic [VAL_W-1:0] RANGE_HI = RANGE_HI_DEF
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // channel inputs
  input wire logic [NUM_CH-1:0][VAL_W-1:0] ch_value,
  input wire logic [NUM_CH-1:0] ch_quality_ok,
  input wire logic [NUM_CH-1:0] ch_bypass,
  // configuration and operator choice
  input wire logic [1:0] cfg_chan_count,
  input wire logic op_select,
  // control output
  output logic [VAL_W-1:0] ctrl_value_q,
  output logic ctrl_valid_q,
  output logic [2:0] sel_mode_q,
  // operator indications
  output logic manual_ctrl_q,
  output logic operator_alert_q,
  output logic bad_notify_q,
  output logic bad_event_q,
  output logic [NUM_CH-1:0] good_mask_q
);
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // carry bit kept so two full-scale codes cannot wrap the sum
  function automatic logic [VAL_W-1:0] avg2(input logic [VAL_W-1:0] a,
                                            input logic [VAL_W-1:0] b);
    logic [VAL_W:0] sum;
    sum = {1'b0, a} + {1'b0, b};
    avg2 = sum[VAL_W:1];
  endfunction

  function automatic logic [2:0] count4(input logic [3:0] m);
    count4 = {2'b00, m[0]} + {2'b00, m[1]} + {2'b00, m[2]} + {2'b00, m[3]};
  endfunction

  // ----------------------------------------------------------------
  // classification
  // ----------------------------------------------------------------
  wire logic two_cfg = (cfg_chan_count == CFG_TWO);
  wire logic [3:0] en_mask = two_cfg ? EN_TWO :
                             (cfg_chan_count == CFG_THREE) ? EN_THREE : EN_FOUR;
  // limitation: default limits accept every code; narrow them per loop
  logic [3:0] in_range;
  always_comb begin
    for (int i = 0; i < NUM_CH; i++) begin
      in_range[i] = (ch_value[i] >= RANGE_LO) && (ch_value[i] <= RANGE_HI);
    end
  end
  // bypassed channels drop out like failed ones
  wire logic [3:0] good = en_mask & ch_quality_ok & ~ch_bypass & in_range;
  wire logic [3:0] bad = en_mask & ~good;
  wire logic [2:0] n_good = count4(good);

  // ----------------------------------------------------------------
  // ranking
  // ----------------------------------------------------------------
  sort_if #(.KW(VAL_W + 1)) srt_bus ();
  // bad keys carry a set msb, so good values fill the low ranks
  assign srt_bus.key[0] = {~good[0], ch_value[0]};
  assign srt_bus.key[1] = {~good[1], ch_value[1]};
  assign srt_bus.key[2] = {~good[2], ch_value[2]};
  assign srt_bus.key[3] = {~good[3], ch_value[3]};

  rank_sorter #(.KW(VAL_W + 1)) u_sorter (
    .s(srt_bus.sorter)
  );

  wire logic [VAL_W-1:0] rank0 = srt_bus.srt[0][VAL_W-1:0];
  wire logic [VAL_W-1:0] rank1 = srt_bus.srt[1][VAL_W-1:0];
  wire logic [VAL_W-1:0] rank2 = srt_bus.srt[2][VAL_W-1:0];

  // ----------------------------------------------------------------
  // selection
  // ----------------------------------------------------------------
  // method keyed on the number of survivors, not on which ones survived
  sel_mode_t mode_d;
  logic [VAL_W-1:0] value_d;
  always_comb begin
    case (n_good)
      3'd0: mode_d = MODE_MANUAL;
      3'd1: mode_d = MODE_SINGLE;
      3'd2: mode_d = two_cfg ? MODE_OPERATOR : MODE_AVG2;
      3'd3: mode_d = MODE_MEDIAN3;
      3'd4: mode_d = MODE_MEDIAN4;
      default: mode_d = MODE_MANUAL;
    endcase
  end

  always_comb begin
    case (mode_d)
      MODE_MEDIAN4: value_d = avg2(rank1, rank2);
      MODE_MEDIAN3: value_d = rank1;
      MODE_AVG2: value_d = avg2(rank0, rank1);
      MODE_OPERATOR: value_d = op_select ? ch_value[1] : ch_value[0];
      MODE_SINGLE: value_d = rank0;
      // manual: last automatic value is held so the loop sees no step
      MODE_MANUAL: value_d = ctrl_value_q;
      default: value_d = ctrl_value_q;
    endcase
  end

  wire logic manual_d = (mode_d == MODE_MANUAL);
  // two-input loss hands over without the alert that three or four raise
  wire logic alert_d = manual_d && !two_cfg;
  wire logic notify_d = |bad;
  wire logic event_d = |(good_mask_q & bad);

  // ----------------------------------------------------------------
  // output registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_value_q <= '0;
      ctrl_valid_q <= 1'b0;
      sel_mode_q <= MODE_RST;
      manual_ctrl_q <= 1'b1;
      operator_alert_q <= 1'b0;
      bad_notify_q <= 1'b0;
      bad_event_q <= 1'b0;
      good_mask_q <= GOOD_MASK_RST;
    end else begin
      ctrl_value_q <= value_d;
      ctrl_valid_q <= !manual_d;
      sel_mode_q <= mode_d;
      manual_ctrl_q <= manual_d;
      operator_alert_q <= alert_d;
      bad_notify_q <= notify_d;
      bad_event_q <= event_d;
      good_mask_q <= good;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  // checks stay quiet while reset holds the registers
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  quality_gate_a: assert property (!ch_quality_ok[0] |=> !good_mask_q[0])
    else $error("bad quality channel counted as good");
  median_four_a: assert property ((n_good == 3'd4) |=>
      (sel_mode_q == MODE_MEDIAN4) && (ctrl_value_q == avg2($past(rank1), $past(rank2))))
    else $error("four-good median wrong");
  bad_notice_a: assert property ((|bad) |=> bad_notify_q)
    else $error("bad channel not notified");
  two_pick_a: assert property ((two_cfg && good[1:0] == 2'b11) |=>
      ctrl_value_q == ($past(op_select) ? $past(ch_value[1]) : $past(ch_value[0])))
    else $error("operator choice not honoured");
  manual_two_a: assert property ((two_cfg && good[1:0] == 2'b00) |=>
      manual_ctrl_q && !operator_alert_q && !ctrl_valid_q && $stable(ctrl_value_q))
    else $error("two-input manual handover wrong");
  single_good_a: assert property ((good == 4'h4) |=>
      ctrl_value_q == $past(ch_value[2]))
    else $error("lone good input not passed");
  lone_second_a: assert property ((two_cfg && good[1:0] == 2'b10) |=>
      ctrl_value_q == $past(ch_value[1]))
    else $error("lone good second input not passed");
  median_three_a: assert property ((n_good == 3'd3) |=>
      (sel_mode_q == MODE_MEDIAN3) && (ctrl_value_q == $past(rank1)))
    else $error("three-good median wrong");
  avg_two_a: assert property ((n_good == 3'd2 && !two_cfg) |=>
      ctrl_value_q == avg2($past(rank0), $past(rank1)))
    else $error("two-good average wrong");
  all_bad_a: assert property ((!two_cfg && good == 4'h0) |=>
      manual_ctrl_q && operator_alert_q && !ctrl_valid_q)
    else $error("all-bad handover or alert missing");
  bypass_excl_a: assert property (ch_bypass[3] |=> !good_mask_q[3])
    else $error("bypassed channel still selected");

  // ----------------------------------------------------------------
  // classification and ranking checks
  // ----------------------------------------------------------------
  mask_quality_a: assert property ((good_mask_q & ~$past(ch_quality_ok)) == 4'h0)
    else $error("failed quality verdict counted as good");
  unconf_two_a: assert property (two_cfg |=> good_mask_q[3:2] == 2'b00)
    else $error("unconfigured channel counted in two-input mode");
  unconf_three_a: assert property ((cfg_chan_count == CFG_THREE) |=> !good_mask_q[3])
    else $error("unconfigured channel counted in three-input mode");
  sorted_order_a: assert property ((n_good >= 3'd3) |->
      (rank0 <= rank1) && (rank1 <= rank2))
    else $error("good values not ranked in order");

  // ----------------------------------------------------------------
  // indication checks
  // ----------------------------------------------------------------
  manual_hold_a: assert property ((n_good == 3'd0) |=>
      $stable(ctrl_value_q) && !ctrl_valid_q)
    else $error("manual handover moved the control value");
  auto_valid_a: assert property ((n_good != 3'd0) |=>
      ctrl_valid_q && !manual_ctrl_q)
    else $error("good input left but loop not automatic");
  event_notify_a: assert property (bad_event_q |-> bad_notify_q)
    else $error("loss event without bad notification");
  event_after_a: assert property (bad_event_q |->
      (|($past(good_mask_q) & ~good_mask_q)))
    else $error("loss event with no channel lost");
  notify_clear_a: assert property ((bad == 4'h0) |=> !bad_notify_q)
    else $error("notification raised with every channel good");
endmodule
`default_nettype wire

// [logic/selector_pkg.sv]
// Purpose: shared constants and types for the redundant channel signal selector
// Assumes: channel values are unsigned, one per redundant protection channel
// Notes: reset values and range defaults are named here once
`default_nettype none
package selector_pkg;
  // ----------------------------------------------------------------
  // widths and defaults
  // ----------------------------------------------------------------
  localparam int VAL_W_DEF = 16;
  localparam int NUM_CH = 4;
  localparam logic [15:0] RANGE_LO_DEF = 16'h0000;
  localparam logic [15:0] RANGE_HI_DEF = 16'hFFFF;

  // ----------------------------------------------------------------
  // channel configurations
  // ----------------------------------------------------------------
  localparam logic [1:0] CFG_TWO = 2'h0;
  localparam logic [1:0] CFG_THREE = 2'h1;
  localparam logic [1:0] CFG_FOUR = 2'h2;
  localparam logic [3:0] EN_TWO = 4'h3;
  localparam logic [3:0] EN_THREE = 4'h7;
  localparam logic [3:0] EN_FOUR = 4'hF;

  // ----------------------------------------------------------------
  // selection modes
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    MODE_MEDIAN3 = 3'b000,
    MODE_MEDIAN4 = 3'b001,
    MODE_AVG2 = 3'b010,
    MODE_SINGLE = 3'b011,
    MODE_OPERATOR = 3'b100,
    MODE_MANUAL = 3'b101
  } sel_mode_t;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam sel_mode_t MODE_RST = MODE_MANUAL;
  localparam logic [3:0] GOOD_MASK_RST = 4'h0;
endpackage
`default_nettype wire

// [logic/sort_if.sv]
// Purpose: carries ranking keys to the sorter and sorted keys back
// Assumes: key msb set means the channel is excluded
// Notes: purely combinational carrier
`default_nettype none
interface sort_if #(parameter int KW = 17);
  logic [KW-1:0] key [4];
  logic [KW-1:0] srt [4];
  modport sorter (input key, output srt);
  modport user (output key, input srt);
endinterface
`default_nettype wire

// [logic/rank_sorter.sv]
// Purpose: ascending sort of four keys by a five-compare network
// Assumes: excluded channels carry a set msb so they sort to the top
// Notes: combinational; the caller registers the result
`default_nettype none
module rank_sorter #(
  parameter int KW = 17
) (
  // sort keys
  sort_if.sorter s
);
  // ----------------------------------------------------------------
  // compare helpers
  // ----------------------------------------------------------------
  function automatic logic [KW-1:0] kmin(input logic [KW-1:0] a, input logic [KW-1:0] b);
    kmin = (a < b) ? a : b;
  endfunction

  function automatic logic [KW-1:0] kmax(input logic [KW-1:0] a, input logic [KW-1:0] b);
    kmax = (a < b) ? b : a;
  endfunction

  // ----------------------------------------------------------------
  // network (0,1)(2,3)(0,2)(1,3)(1,2)
  // ----------------------------------------------------------------
  wire logic [KW-1:0] l01 = kmin(s.key[0], s.key[1]);
  wire logic [KW-1:0] h01 = kmax(s.key[0], s.key[1]);
  wire logic [KW-1:0] l23 = kmin(s.key[2], s.key[3]);
  wire logic [KW-1:0] h23 = kmax(s.key[2], s.key[3]);
  wire logic [KW-1:0] mid_a = kmax(l01, l23);
  wire logic [KW-1:0] mid_b = kmin(h01, h23);

  assign s.srt[0] = kmin(l01, l23);
  assign s.srt[1] = kmin(mid_a, mid_b);
  assign s.srt[2] = kmax(mid_a, mid_b);
  assign s.srt[3] = kmax(h01, h23);
endmodule
`default_nettype wire

// [tb/channel_source.sv]
// Purpose: model of the redundant protection channels feeding the selector
// Assumes: one-way isolated links, refreshed on every rising clk_sys edge
// Notes: the bench sets what each channel reports, one cycle ahead
`default_nettype none
module channel_source
  import selector_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // what each channel should report next
  input wire logic [NUM_CH-1:0][VAL_W_DEF-1:0] set_value,
  input wire logic [NUM_CH-1:0] set_ok,
  input wire logic [NUM_CH-1:0] set_byp,
  // isolated channel links
  output logic [NUM_CH-1:0][VAL_W_DEF-1:0] ch_value,
  output logic [NUM_CH-1:0] ch_quality_ok,
  output logic [NUM_CH-1:0] ch_bypass
);
  timeunit 1ns;
  timeprecision 1ps;
  // links come up reporting bad, like a channel still booting
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      ch_value <= '0;
      ch_quality_ok <= 4'h0;
      ch_bypass <= 4'h0;
    end else begin
      ch_value <= set_value;
      ch_quality_ok <= set_ok;
      ch_bypass <= set_byp;
    end
  end
endmodule
`default_nettype wire

// [tb/tb_signal_selector.sv]
// Purpose: self-checking bench for the redundant channel signal selector
// Assumes: two cycles from a bench change to a settled selector output
// Notes: manual cases expect the last automatic value to be held
`default_nettype none
module tb_signal_selector
  import selector_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic [NUM_CH-1:0][VAL_W_DEF-1:0] set_value = {16'h001F, 16'h0014, 16'h0028, 16'h000B};
  logic [3:0] set_ok = 4'h0;
  logic [3:0] set_byp = 4'h0;
  logic [NUM_CH-1:0][VAL_W_DEF-1:0] ch_value;
  logic [3:0] ch_quality_ok, ch_bypass, good_mask_q;
  logic [1:0] cfg = 2'h2;
  logic op = 1'b0;
  logic [15:0] ctrl_value_q;
  logic [2:0] sel_mode_q;
  logic ctrl_valid_q, manual_ctrl_q, operator_alert_q, bad_notify_q, bad_event_q;
  int fails = 0;
  int n_checks = 0;
  int cycles = 0;

  always #10 clk_sys = ~clk_sys;

  channel_source i_channel_source (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .set_value(set_value), .set_ok(set_ok), .set_byp(set_byp), .ch_value(ch_value),
    .ch_quality_ok(ch_quality_ok), .ch_bypass(ch_bypass));
  signal_selector i_signal_selector (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .ch_value(ch_value), .ch_quality_ok(ch_quality_ok), .ch_bypass(ch_bypass),
    .cfg_chan_count(cfg), .op_select(op), .ctrl_value_q(ctrl_value_q),
    .ctrl_valid_q(ctrl_valid_q), .sel_mode_q(sel_mode_q), .manual_ctrl_q(manual_ctrl_q),
    .operator_alert_q(operator_alert_q), .bad_notify_q(bad_notify_q),
    .bad_event_q(bad_event_q), .good_mask_q(good_mask_q));

  // ----------------------------------------------------------------
  // shared helpers
  // ----------------------------------------------------------------
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // flags: manual, alert, notify; valid must be the inverse of manual
  task automatic step(input logic [1:0] c, input logic o, input logic [3:0] ok,
                      input logic [3:0] byp, input logic [15:0] ev,
                      input logic [2:0] em, input logic [2:0] fl);
    @(posedge clk_sys);
    cfg <= c;
    op <= o;
    set_ok <= ok;
    set_byp <= byp;
    repeat (2) @(posedge clk_sys);
    #1;
    cmp(ctrl_value_q, ev);
    cmp(16'(sel_mode_q), 16'(em));
    cmp(16'({manual_ctrl_q, operator_alert_q, bad_notify_q}), 16'(fl));
    cmp(16'(ctrl_valid_q), 16'(!fl[2]));
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  // channel values: ch0 11, ch1 40, ch2 20, ch3 31
  task automatic four_channels();
    step(2'h2, 1'b0, 4'hF, 4'h0, 16'h0019, MODE_MEDIAN4, 3'b000);
    step(2'h2, 1'b0, 4'hF, 4'h8, 16'h0014, MODE_MEDIAN3, 3'b001);
    cmp(16'(bad_event_q), 16'h0001);
    cmp(16'(good_mask_q), 16'h0007);
    @(posedge clk_sys);
    #1;
    cmp(16'(bad_event_q), 16'h0000);
    step(2'h2, 1'b0, 4'hC, 4'h0, 16'h0019, MODE_AVG2, 3'b001);
    step(2'h2, 1'b0, 4'h4, 4'h0, 16'h0014, MODE_SINGLE, 3'b001);
    step(2'h2, 1'b0, 4'h0, 4'h0, 16'h0014, MODE_MANUAL, 3'b111);
    // code 3 runs as four inputs; ch2 failed leaves 11, 40, 31
    step(2'h3, 1'b0, 4'hB, 4'h0, 16'h001F, MODE_MEDIAN3, 3'b001);
  endtask

  task automatic three_channels();
    step(2'h1, 1'b0, 4'hF, 4'h0, 16'h0014, MODE_MEDIAN3, 3'b000);
    step(2'h1, 1'b0, 4'h5, 4'h0, 16'h000F, MODE_AVG2, 3'b001);
    step(2'h1, 1'b0, 4'h7, 4'h1, 16'h001E, MODE_AVG2, 3'b001);
    step(2'h1, 1'b0, 4'h4, 4'h0, 16'h0014, MODE_SINGLE, 3'b001);
    step(2'h1, 1'b0, 4'h8, 4'h0, 16'h0014, MODE_MANUAL, 3'b111);
  endtask

  task automatic two_channels();
    step(2'h0, 1'b1, 4'hF, 4'h0, 16'h0028, MODE_OPERATOR, 3'b000);
    step(2'h0, 1'b0, 4'hF, 4'h0, 16'h000B, MODE_OPERATOR, 3'b000);
    step(2'h0, 1'b0, 4'h2, 4'h0, 16'h0028, MODE_SINGLE, 3'b001);
    step(2'h0, 1'b1, 4'hC, 4'h0, 16'h0028, MODE_MANUAL, 3'b101);
  endtask

  // reset in mid-run: outputs back to reset state, then a clean recovery
  task automatic mid_reset();
    @(posedge clk_sys);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    sys_rst <= 1'b0;
    #1;
    cmp(16'({manual_ctrl_q, ctrl_valid_q, sel_mode_q}), 16'h0015);
    cmp(ctrl_value_q, 16'h0000);
    cmp(16'({bad_event_q, bad_notify_q, operator_alert_q, good_mask_q}), 16'h0000);
    step(2'h2, 1'b0, 4'hF, 4'h0, 16'h0019, MODE_MEDIAN4, 3'b000);
    cmp(16'(bad_event_q), 16'h0000);
  endtask

  // ----------------------------------------------------------------
  // main sequence and hang guard
  // ----------------------------------------------------------------
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      fails++;
      wrap_up();
    end
  end

  initial begin
    repeat (2) @(posedge clk_sys);
    sys_rst <= 1'b0;
    #1;
    cmp(16'({manual_ctrl_q, ctrl_valid_q, sel_mode_q}), 16'h0015);
    four_channels();
    three_channels();
    two_channels();
    mid_reset();
    wrap_up();
  end
endmodule
`default_nettype wire
